// ---- src/seg_host_pkg.sv ----
// Package for the host that drives a BCD seven-segment decoder through its pins.
// Assumes a single 200 MHz clock and a decoder whose segment pins settle within 100 ns.
package seg_host_pkg;

	// Clock and settle timing
	localparam int CLK_PERIOD_PS    = 5000;
	localparam int SETTLE_TIME_NS   = 100;
	localparam int SETTLE_CYCLES    = (SETTLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// Widths
	localparam int CODE_W           = 4;
	localparam int SEG_W            = 7;
	localparam int CNT_W            = 8;

	// Constant patterns, segment a in the top bit
	localparam logic [SEG_W-1:0] SEG_NONE = 7'h00;
	localparam logic [SEG_W-1:0] SEG_ALL  = 7'h7F;
	localparam logic [CODE_W-1:0] CODE_ZERO = 4'h0;

	// What the host asks of the decoder for one digit
	typedef enum logic [2:0] {
		MODE_SHOW,     // Plain decode, zero shown
		MODE_SUPPRESS, // Zero blanked when code is zero
		MODE_RIPPLE,   // Zero blanking follows the stage before
		MODE_BLANK,    // Forced blanking through the shared node
		MODE_TEST      // All segments lit
	} mode_t;

	typedef struct packed {
		mode_t             mode;
		logic [CODE_W-1:0] code;
	} cmd_t;

	typedef struct packed {
		logic [SEG_W-1:0] seg;     // Segment levels as lit flags
		logic             nodeLow; // Shared blank node seen low
		logic             match;   // Readback equals expectation
	} result_t;

	// Pins that the host drives toward the decoder
	typedef struct packed {
		logic [CODE_W-1:0] code;
		logic              zeroBlankIn;
		logic              allSegmentsTest;
		logic              nodeOe;
	} pins_t;

endpackage

// ---- src/seg_glyph_ref.sv ----
// Expected segment pattern for one decoder stage, as lit flags (a in top bit).
// Assumes inputs are the pin levels the host is driving; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module seg_glyph_ref (
	input  wire logic [seg_host_pkg::CODE_W-1:0] code,        // BCD code driven
	input  wire logic                            forceBlank,  // Shared node pulled low
	input  wire logic                            testLow,     // Lamp test pin low
	input  wire logic                            zeroBlankIn, // Zero blank pin level
	output logic      [seg_host_pkg::SEG_W-1:0]  litExp,      // Expected lit flags
	output logic                                 nodeLowExp   // Expected node low from the zero response
);

	// Glyph table; codes ten to fourteen give fixed sign patterns, code fifteen is dark
	function automatic logic [seg_host_pkg::SEG_W-1:0] glyph(input logic [seg_host_pkg::CODE_W-1:0] c);
		case (c)
			4'h0: glyph = 7'h7E;
			4'h1: glyph = 7'h30;
			4'h2: glyph = 7'h6D;
			4'h3: glyph = 7'h79;
			4'h4: glyph = 7'h33;
			4'h5: glyph = 7'h5B;
			4'h6: glyph = 7'h1F;
			4'h7: glyph = 7'h70;
			4'h8: glyph = 7'h7F;
			4'h9: glyph = 7'h73;
			4'hA: glyph = 7'h0D;
			4'hB: glyph = 7'h19;
			4'hC: glyph = 7'h23;
			4'hD: glyph = 7'h4B;
			4'hE: glyph = 7'h0F;
			default: glyph = seg_host_pkg::SEG_NONE;
		endcase
	endfunction

	// Priority: forced blank, then test, then zero response, then glyph
	always_comb begin
		nodeLowExp = 1'b0;
		if (forceBlank) begin
			litExp = seg_host_pkg::SEG_NONE;
		end else if (!zeroBlankIn && code == seg_host_pkg::CODE_ZERO && !testLow) begin
			litExp     = seg_host_pkg::SEG_NONE;
			nodeLowExp = 1'b1;
		end else if (testLow) begin
			litExp = seg_host_pkg::SEG_ALL;
		end else begin
			litExp = glyph(code);
		end
	end

endmodule // seg_glyph_ref
`default_nettype wire

// ---- src/seg_decoder_host.sv ----
// Host controller that drives a BCD seven-segment decoder through its pins and reads it back.
// Assumes the decoder pins are synchronous to sys_clk once settled, and an external pull-up on
// the shared blank node, which the host only ever pulls low.
`timescale 1ns/1ps
`default_nettype none
module seg_decoder_host #(
	parameter bit ACTIVE_LOW    = 1'b1,                        // Segment lit level is 0
	parameter int SETTLE_CYCLES = seg_host_pkg::SETTLE_CYCLES  // Cycles before readback
) (
	input  wire logic                           sys_clk,     // System clock
	input  wire logic                           rst,         // Synchronous reset, high
	input  wire logic                           cmdValid,    // Order offered
	input  wire seg_host_pkg::cmd_t             cmd,         // Mode and code
	output logic                                cmdReady,    // Host idle, order taken
	output logic                                resValid,    // Readback pulse
	output seg_host_pkg::result_t               res,         // Readback and verdict
	output seg_host_pkg::pins_t                 pins,        // Pins toward the decoder
	input  wire logic [seg_host_pkg::SEG_W-1:0] segIn,       // Segment pins a..g
	input  wire logic                           nodeIn,      // Shared blank node level
	input  wire logic                           upstreamIn   // Previous stage zero-blank out
);

	localparam int SettleCyc = SETTLE_CYCLES;

	// Counter must reach the settle time; a zero wait would sample stale pins
	if (SETTLE_CYCLES < 1 || SETTLE_CYCLES >= (1 << seg_host_pkg::CNT_W)) begin : g_bad_settle
		$error("SETTLE_CYCLES out of range");
	end

	typedef enum {ST_IDLE, ST_SETTLE} state_t;

	state_t                           stateQ;
	seg_host_pkg::mode_t              modeQ;
	logic [seg_host_pkg::CNT_W-1:0]   cntQ;
	logic [seg_host_pkg::SEG_W-1:0]   litExp;
	logic [seg_host_pkg::SEG_W-1:0]   litSeen;
	logic                             nodeLowExp;
	logic                             accept;
	logic                             zeroBlankD;

	// Order taken only while idle; a held cmdValid is taken again once the host is back in idle
	assign accept = cmdValid && cmdReady && stateQ == ST_IDLE;

	// Read pins as lit flags regardless of part polarity
	assign litSeen = ACTIVE_LOW ? ~segIn : segIn;

	// Zero-blank level for the mode; ripple copies the stage before
	always_comb begin
		case (cmd.mode)
			seg_host_pkg::MODE_SUPPRESS: zeroBlankD = 1'b0;
			seg_host_pkg::MODE_RIPPLE:   zeroBlankD = upstreamIn;
			default:                     zeroBlankD = 1'b1;
		endcase
	end

	// Sequencer: drive pins, wait for the decoder to settle, sample once
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			stateQ   <= ST_IDLE;
			cntQ     <= '0;
			cmdReady <= 1'b0;
		end else begin
			case (stateQ)
				ST_IDLE: begin
					cmdReady <= 1'b1;
					if (accept) begin
						stateQ   <= ST_SETTLE;
						cntQ     <= seg_host_pkg::CNT_W'(SETTLE_CYCLES - 1);
						cmdReady <= 1'b0;
					end
				end
				ST_SETTLE: begin
					if (cntQ == '0) begin
						stateQ   <= ST_IDLE;
						cmdReady <= 1'b1;
					end else begin
						cntQ <= cntQ - 1'b1;
					end
				end
				default: stateQ <= ST_IDLE;
			endcase
		end
	end

	// Pin drive; node is released except in forced blanking
	// Reset leaves lamp test and zero-blank released so the part decodes plainly
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pins.code            <= seg_host_pkg::CODE_ZERO;
			pins.zeroBlankIn     <= 1'b1;
			pins.allSegmentsTest <= 1'b1;
			pins.nodeOe          <= 1'b0;
			modeQ                <= seg_host_pkg::MODE_SHOW;
		end else begin
			if (accept) begin
				pins.code            <= cmd.code;
				pins.zeroBlankIn     <= zeroBlankD;
				pins.allSegmentsTest <= cmd.mode != seg_host_pkg::MODE_TEST;
				pins.nodeOe          <= cmd.mode == seg_host_pkg::MODE_BLANK;
				modeQ                <= cmd.mode;
			end else if (modeQ == seg_host_pkg::MODE_RIPPLE) begin
				pins.zeroBlankIn <= upstreamIn;
			end
		end
	end

	// Expectation from the pins currently driven
	seg_glyph_ref u_ref (
		.code       (pins.code),
		.forceBlank (pins.nodeOe),
		.testLow    (!pins.allSegmentsTest),
		.zeroBlankIn(pins.zeroBlankIn),
		.litExp     (litExp),
		.nodeLowExp (nodeLowExp)
	);

	// Readback capture; node low seen while not driving means a zero response
	// One sample at the last settle edge; a slower part needs a larger SETTLE_CYCLES
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			resValid    <= 1'b0;
			res.seg     <= seg_host_pkg::SEG_NONE;
			res.nodeLow <= 1'b0;
			res.match   <= 1'b0;
		end else begin
			resValid <= 1'b0;
			if (stateQ == ST_SETTLE && cntQ == '0) begin
				resValid    <= 1'b1;
				res.seg     <= litSeen;
				res.nodeLow <= !nodeIn;
				res.match   <= litSeen == litExp && (!nodeIn) == (nodeLowExp || pins.nodeOe);
			end
		end
	end

	// Node pulled low only when blanking is ordered
	a_node_release: assert property (@(posedge sys_clk) disable iff (rst)
		pins.nodeOe |-> modeQ == seg_host_pkg::MODE_BLANK)
		else $error("shared node driven outside forced blanking");

	// Zero shown: zero-blank pin stays high in show mode
	a_zero_shown: assert property (@(posedge sys_clk) disable iff (rst)
		(modeQ == seg_host_pkg::MODE_SHOW || modeQ == seg_host_pkg::MODE_TEST) |-> pins.zeroBlankIn)
		else $error("zero-blank pin low while zero must show");

	// Ripple mode follows the upstream stage one cycle later
	a_ripple_follow: assert property (@(posedge sys_clk) disable iff (rst)
		(modeQ == seg_host_pkg::MODE_RIPPLE && stateQ == ST_SETTLE && $past(stateQ) == ST_SETTLE)
		|-> pins.zeroBlankIn == $past(upstreamIn))
		else $error("zero-blank pin not following upstream stage");

	// Readback arrives exactly the settle time after acceptance
	a_settle_time: assert property (@(posedge sys_clk) disable iff (rst)
		accept |-> ##1 !resValid ##SettleCyc resValid)
		else $error("readback not at settle time");

	// Pins stay put while settling, except the zero-blank pin in ripple mode
	a_pins_hold: assert property (@(posedge sys_clk) disable iff (rst)
		(stateQ == ST_SETTLE && $past(stateQ) == ST_SETTLE && modeQ != seg_host_pkg::MODE_RIPPLE)
		|-> $stable(pins))
		else $error("pins changed during settle");

	// No new order is taken while settling
	a_ready_busy: assert property (@(posedge sys_clk) disable iff (rst)
		stateQ == ST_SETTLE |-> !cmdReady)
		else $error("ready raised while settling");

	// Lamp test pin pulled low only for a lamp test order
	a_test_pin: assert property (@(posedge sys_clk) disable iff (rst)
		!pins.allSegmentsTest |-> modeQ == seg_host_pkg::MODE_TEST)
		else $error("lamp test pin low outside test mode");

	// Suppress mode keeps the zero-blank pin low
	a_suppress_pin: assert property (@(posedge sys_clk) disable iff (rst)
		modeQ == seg_host_pkg::MODE_SUPPRESS |-> !pins.zeroBlankIn)
		else $error("zero-blank pin high in suppress mode");

	// Forced blanking reads back dark segments and a low node
	a_blank_seen: assert property (@(posedge sys_clk) disable iff (rst)
		(resValid && pins.nodeOe) |-> (res.nodeLow && res.seg == seg_host_pkg::SEG_NONE))
		else $error("segments lit under forced blanking");

	// Readback is a single-cycle pulse
	a_pulse_once: assert property (@(posedge sys_clk) disable iff (rst)
		resValid |=> !resValid)
		else $error("readback pulse longer than one cycle");

	// Ready rises on the same edge as the readback pulse
	a_ready_after: assert property (@(posedge sys_clk) disable iff (rst)
		resValid |-> cmdReady)
		else $error("ready low while readback valid");

	// A taken order drops ready at once
	a_one_order: assert property (@(posedge sys_clk) disable iff (rst)
		accept |=> (!cmdReady && stateQ == ST_SETTLE))
		else $error("order taken without entering settle");

	c_blank_run: cover property (@(posedge sys_clk) disable iff (rst)
		resValid && modeQ == seg_host_pkg::MODE_BLANK);
	c_zero_resp: cover property (@(posedge sys_clk) disable iff (rst)
		resValid && res.nodeLow && modeQ == seg_host_pkg::MODE_SUPPRESS);
	c_match_show: cover property (@(posedge sys_clk) disable iff (rst)
		resValid && res.match && modeQ == seg_host_pkg::MODE_SHOW);
	// Lamp test and a zero blanked by the stage before
	c_test_run: cover property (@(posedge sys_clk) disable iff (rst)
		resValid && modeQ == seg_host_pkg::MODE_TEST);
	c_ripple_zero: cover property (@(posedge sys_clk) disable iff (rst)
		resValid && res.nodeLow && modeQ == seg_host_pkg::MODE_RIPPLE);

endmodule // seg_decoder_host
`default_nettype wire

// ---- verification/seg_decoder_model.sv ----
// Behavioural model of one BCD seven-segment decoder stage.
// Assumes the shared blank node is resolved outside with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module seg_decoder_model #(
	parameter bit ACTIVE_LOW = 1'b1 // Lit segment pin level is 0
) (
	input  wire logic [3:0] code,    // BCD code pins
	input  wire logic       zbIn,    // Zero-blank input
	input  wire logic       testIn,  // Lamp test, low lights all
	input  wire logic       nodeIn,  // Resolved shared node
	output logic      [6:0] segOut,  // Segment pins a..g
	output logic            nodePull // High while pulling node low
);
	localparam logic [6:0] GLYPH [16] = '{7'h7E, 7'h30, 7'h6D, 7'h79, 7'h33, 7'h5B, 7'h1F, 7'h70,
		7'h7F, 7'h73, 7'h0D, 7'h19, 7'h23, 7'h4B, 7'h0F, 7'h00};
	logic [6:0] lit;
	// Zero response; lamp test wins, so it needs the test pin idle
	assign nodePull = !zbIn && code == 4'h0 && testIn;
	// Node low blanks first, since the own pull must blank too
	always_comb begin
		if (!nodeIn)
			lit = 7'h00;
		else if (!testIn)
			lit = 7'h7F;
		else
			lit = GLYPH[code];
	end
	// All segments flip together
	assign segOut = ACTIVE_LOW ? ~lit : lit;
endmodule // seg_decoder_model
`default_nettype wire

// ---- verification/tb_seg_decoder_host.sv ----
// Testbench: both polarities of the host side by side, each facing a decoder model.
// Assumes SETTLE_CYCLES can be cut to 2; the blank node has a pull-up.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; $display("ERROR %s exp %h seen %h", nm, e, g); end end
module tb_seg_decoder_host;
	localparam int SETTLE = 2; // Settle cycles given to both hosts
	localparam logic [6:0] GLYPH [16] = '{7'h7E, 7'h30, 7'h6D, 7'h79, 7'h33, 7'h5B, 7'h1F, 7'h70,
		7'h7F, 7'h73, 7'h0D, 7'h19, 7'h23, 7'h4B, 7'h0F, 7'h00};
	logic                  sys_clk    = 1'b0;
	logic                  rst        = 1'b1;
	logic                  cmdValid   = 1'b0;
	seg_host_pkg::cmd_t    cmd        = '0;
	logic                  upstreamIn = 1'b1;
	wire                   rdy [2];
	wire                   rv [2];
	wire                   pull [2];
	wire                   node [2];
	wire [6:0]             seg [2];
	seg_host_pkg::result_t res [2];
	seg_host_pkg::pins_t   pins [2];
	int                    n_errors   = 0;
	int                    num_checks = 0;
	always #2.5 sys_clk = ~sys_clk;
	// Index 0 is the active-low part, 1 the active-high part
	for (genvar i = 0; i < 2; i++) begin : g_pol
		// Wired node: pull-up unless either party pulls it low
		assign node[i] = ~(pins[i].nodeOe | pull[i]);
		seg_decoder_host #(.ACTIVE_LOW(i == 0), .SETTLE_CYCLES(SETTLE)) dut (.sys_clk(sys_clk), .rst(rst),
			.cmdValid(cmdValid), .cmd(cmd), .cmdReady(rdy[i]), .resValid(rv[i]), .res(res[i]), .pins(pins[i]),
			.segIn(seg[i]), .nodeIn(node[i]), .upstreamIn(upstreamIn));
		seg_decoder_model #(.ACTIVE_LOW(i == 0)) model (.code(pins[i].code), .zbIn(pins[i].zeroBlankIn),
			.testIn(pins[i].allSegmentsTest), .nodeIn(node[i]), .segOut(seg[i]), .nodePull(pull[i]));
	end
	task automatic tally_and_finish();
		$display("Checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// One order to both hosts, then pins and readback judged
	task automatic run(seg_host_pkg::mode_t m, logic [3:0] c, logic up);
		logic [6:0] e;
		logic       nl;
		logic       zb;
		int         k;
		zb = (m == seg_host_pkg::MODE_SUPPRESS) ? 1'b0 : (m == seg_host_pkg::MODE_RIPPLE) ? up : 1'b1;
		nl = (m == seg_host_pkg::MODE_BLANK) || (!zb && c == 4'h0);
		e = nl ? 7'h00 : (m == seg_host_pkg::MODE_TEST) ? 7'h7F : GLYPH[c];
		@(negedge sys_clk);
		for (k = 0; k < 20 && !(rdy[0] === 1'b1 && rdy[1] === 1'b1); k++)
			@(negedge sys_clk);
		`CHK("ready", 1'b1, rdy[0] === 1'b1 && rdy[1] === 1'b1)
		upstreamIn = up;
		cmd = '{mode: m, code: c};
		cmdValid = 1'b1;
		@(negedge sys_clk);
		cmdValid = 1'b0;
		for (int i = 0; i < 2; i++) begin
			`CHK("busy", 1'b0, rdy[i])
			`CHK("pins", {c, zb, m != seg_host_pkg::MODE_TEST, m == seg_host_pkg::MODE_BLANK}, pins[i])
		end
		for (k = 0; k < 20 && rv[0] !== 1'b1; k++)
			@(negedge sys_clk);
		`CHK("latency", SETTLE, k)
		for (int i = 0; i < 2; i++) begin
			`CHK("resValid", 1'b1, rv[i])
			`CHK("seg", e, res[i].seg)
			`CHK("nodeLow", nl, res[i].nodeLow)
			`CHK("match", 1'b1, res[i].match)
		end
	endtask
	// Every code decoded; zero shows even with upstream blanked
	task automatic t_show();
		for (int c = 0; c < 16; c++)
			run(seg_host_pkg::MODE_SHOW, 4'(c), 1'b0);
	endtask
	task automatic t_suppress();
		run(seg_host_pkg::MODE_SUPPRESS, 4'h0, 1'b1);
		run(seg_host_pkg::MODE_SUPPRESS, 4'h7, 1'b1);
	endtask
	task automatic t_ripple();
		run(seg_host_pkg::MODE_RIPPLE, 4'h0, 1'b0);
		run(seg_host_pkg::MODE_RIPPLE, 4'h0, 1'b1);
		run(seg_host_pkg::MODE_RIPPLE, 4'h9, 1'b0);
		// Zero-blank pin keeps following the stage before after the order
		upstreamIn = 1'b1;
		@(negedge sys_clk);
		for (int i = 0; i < 2; i++)
			`CHK("follow", 1'b1, pins[i].zeroBlankIn)
	endtask
	task automatic t_blank();
		run(seg_host_pkg::MODE_BLANK, 4'h8, 1'b1);
		run(seg_host_pkg::MODE_BLANK, 4'h0, 1'b0);
	endtask
	task automatic t_test();
		run(seg_host_pkg::MODE_TEST, 4'h0, 1'b0);
		run(seg_host_pkg::MODE_TEST, 4'hF, 1'b1);
	endtask
	initial begin
		repeat (20) @(negedge sys_clk);
		rst = 1'b0;
		t_show();
		t_suppress();
		t_ripple();
		t_blank();
		t_test();
		t_show();
		tally_and_finish();
	end
	// Whole run needs well under a thousand cycles
	initial begin
		#25000;
		n_errors++;
		$display("ERROR watchdog exp done seen hang");
		tally_and_finish();
	end
endmodule // tb_seg_decoder_host
`default_nettype wire
